// >>> src/scr_pkg.sv
// constants for the spi protocol configuration and status register pair
package scr_pkg;

  // register map, memory map select zero
  localparam logic [3:0]  MMS_ZERO         = 4'h0;
  localparam logic [15:0] CFG_ADDR         = 16'h0004;
  localparam logic [15:0] STS_ADDR         = 16'h0008;

  // control header layout
  localparam int          HDR_WNR_BIT      = 31;
  localparam int          HDR_MMS_LSB      = 16;
  localparam int          WORD_BITS        = 32;

  // configuration field positions
  localparam int          CFG_SYNC_BIT     = 15;
  localparam int          CFG_FCSVE_BIT    = 14;
  localparam int          CFG_CSALIGN_BIT  = 13;
  localparam int          CFG_ZALIGN_BIT   = 12;
  localparam int          CFG_THR_LSB      = 10;
  localparam int          CFG_TX_CUT_THROUGH_EN_BIT    = 9;
  localparam int          CFG_RX_CUT_THROUGH_EN_BIT    = 8;
  localparam int          CFG_PROT_BIT     = 5;
  localparam int          CFG_CPS_LSB      = 0;

  // status field positions
  localparam int          STS_CONTROL_PROTECTION_ERROR_BIT     = 12;
  localparam int          STS_FCSE_BIT     = 11;

  // reset values and chunk payload size codes
  localparam logic [2:0]  CPS_RST          = 3'h6;
  localparam logic [2:0]  CPS_MIN          = 3'h3;
  localparam logic [2:0]  CPS_MAX          = 3'h6;
  localparam logic [1:0]  THR_RST          = 2'h0;

  // credits needed to leave starvation for each threshold code
  function automatic logic [7:0] thr_credits(input logic [1:0] code);
    logic [7:0] val;
    val = 8'h01;
    unique case (code)
      2'h0: val = 8'h01;
      2'h1: val = 8'h04;
      2'h2: val = 8'h08;
      2'h3: val = 8'h10;
    endcase
    return val;
  endfunction : thr_credits

endpackage : scr_pkg

// >>> src/scr_pin_sync.sv
// two flip-flop synchronisers for pins from outside the clock domain
module scr_pin_sync #(
  parameter int         WIDTH = 3,
  parameter logic [2:0] RST_V = 3'h0
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_r[g] <= RST_V[g];
          sync_o[g] <= RST_V[g];
        end else begin
          meta_r[g] <= pin_i[g];
          sync_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule : scr_pin_sync

// >>> src/scr_chunk_check.sv
// checks transmit chunk header offsets against the chunk payload size
module scr_chunk_check (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       hdr_valid_i,
  input  wire logic       start_valid_i,
  input  wire logic       end_valid_i,
  input  wire logic [3:0] start_word_offset_i,
  input  wire logic [5:0] end_byte_offset_i,
  input  wire logic [2:0] chunk_payload_size_i,
  output logic            proto_err_o
);

  logic [7:0] payload_bytes;
  logic [7:0] start_byte;
  logic       swo_bad;
  logic       ebo_bad;

  assign payload_bytes = 8'(8'h08 << (chunk_payload_size_i - scr_pkg::CPS_MIN));
  assign start_byte    = {2'h0, start_word_offset_i, 2'h0};
  assign swo_bad       = start_valid_i && (start_byte >= payload_bytes);
  assign ebo_bad       = end_valid_i && ({2'h0, end_byte_offset_i} >= payload_bytes);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      proto_err_o <= 1'b0;
    end else begin
      proto_err_o <= hdr_valid_i && (swo_bad || ebo_bad);
    end
  end

  AST_OFFSET_BEYOND: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    hdr_valid_i && start_valid_i && (start_byte >= payload_bytes) |=> proto_err_o)
    else $error("start offset beyond payload not flagged");

endmodule : scr_chunk_check

// >>> src/scr_regs.sv
// spi protocol configuration and status registers with control transaction port
////////////////////////////////////////////////////////////////////////////////
module scr_regs (
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_o,
  input  wire logic       tx_host_fcs_bad_i,
  input  wire logic [7:0] tx_credits_available_i,
  input  wire logic       tx_hdr_valid_i,
  input  wire logic       tx_start_valid_i,
  input  wire logic       tx_end_valid_i,
  input  wire logic [3:0] tx_start_word_offset_i,
  input  wire logic [5:0] tx_end_byte_offset_i,
  output logic            frames_accept_o,
  output logic            tx_check_seq_validate_en_o,
  output logic            chip_select_rx_align_en_o,
  output logic            zero_offset_rx_align_en_o,
  output logic            tx_cut_through_en_o,
  output logic            rx_cut_through_en_o,
  output logic            control_protection_en_o,
  output logic [2:0]      chunk_payload_size_o,
  output logic            tx_protocol_error_o,
  output logic            interrupt_out_n_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [2:0] pins_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       mosi_s;
  logic       sclk_d_r;
  logic       cs_n_d_r;

  scr_pin_sync #(
    .WIDTH (3),
    .RST_V (3'h4)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .pin_i   ({chip_select_n_i, spi_sclk_i, spi_mosi_i}),
    .sync_o  (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_start;

  assign sclk_rise = !cs_n_s && sclk_s && !sclk_d_r;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_d_r;
  assign cs_start  = !cs_n_s && cs_n_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // control transaction shifter: header, data word, optional complement word
  logic [6:0]  bit_cnt_r;
  logic [31:0] shift_in_r;
  logic [31:0] hdr_r;
  logic [31:0] data_r;
  logic [31:0] out_sh_r;
  logic [31:0] word_in;
  logic        hdr_done;
  logic        data_done;
  logic        chk_done;

  assign word_in   = {shift_in_r[30:0], mosi_s};
  assign hdr_done  = sclk_rise && (bit_cnt_r == 7'h1F);
  assign data_done = sclk_rise && (bit_cnt_r == 7'h3F);
  assign chk_done  = sclk_rise && (bit_cnt_r == 7'h5F);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_r  <= 7'h00;
      shift_in_r <= 32'h0000_0000;
      hdr_r      <= 32'h0000_0000;
      data_r     <= 32'h0000_0000;
    end else if (cs_n_s) begin
      bit_cnt_r  <= 7'h00;
    end else if (sclk_rise) begin
      bit_cnt_r  <= (bit_cnt_r == 7'h5F) ? 7'h00 : bit_cnt_r + 7'h01;
      shift_in_r <= word_in;
      if (hdr_done) begin
        hdr_r  <= word_in;
      end
      if (data_done) begin
        data_r <= word_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  logic       sync_r;
  logic       fcsve_r;
  logic       csalign_r;
  logic       zalign_r;
  logic [1:0] thr_r;
  logic       tx_cut_through_en_r;
  logic       rx_cut_through_en_r;
  logic       prot_r;
  logic [2:0] cps_r;
  logic       control_protection_error_r;
  logic       tx_host_check_seq_error_r;

  logic [31:0] cfg_rd;
  logic [31:0] sts_rd;

  assign cfg_rd = {16'h0000, sync_r, fcsve_r, csalign_r, zalign_r, thr_r,
                   tx_cut_through_en_r, rx_cut_through_en_r, 2'h0, prot_r, 2'h0, cps_r};
  assign sts_rd = {19'h0_0000, control_protection_error_r, tx_host_check_seq_error_r, 11'h000};

  ////////////////////////////////////////////////////////////////////////////////
  // address decode and write commit
  logic        hdr_wnr;
  logic        hit_cfg;
  logic        hit_sts;
  logic [31:0] rd_word;
  logic        rd_hit_cfg;
  logic        rd_hit_sts;
  logic        wr_commit;
  logic        prot_err_set;
  logic        wr_cfg;
  logic        wr_sts;
  logic        cps_legal;
  logic [31:0] wr_word;
  logic [2:0]  wr_word_cps;

  localparam int HDR_MMS_HI = scr_pkg::HDR_MMS_LSB + 3;

  assign rd_hit_cfg = (word_in[HDR_MMS_HI:scr_pkg::HDR_MMS_LSB] == scr_pkg::MMS_ZERO)
                      && (word_in[15:0] == scr_pkg::CFG_ADDR);
  assign rd_hit_sts = (word_in[HDR_MMS_HI:scr_pkg::HDR_MMS_LSB] == scr_pkg::MMS_ZERO)
                      && (word_in[15:0] == scr_pkg::STS_ADDR);
  assign rd_word    = rd_hit_cfg ? cfg_rd : (rd_hit_sts ? sts_rd : 32'h0000_0000);

  assign hdr_wnr      = hdr_r[scr_pkg::HDR_WNR_BIT];
  assign hit_cfg      = (hdr_r[HDR_MMS_HI:scr_pkg::HDR_MMS_LSB] == scr_pkg::MMS_ZERO)
                        && (hdr_r[15:0] == scr_pkg::CFG_ADDR);
  assign hit_sts      = (hdr_r[HDR_MMS_HI:scr_pkg::HDR_MMS_LSB] == scr_pkg::MMS_ZERO)
                        && (hdr_r[15:0] == scr_pkg::STS_ADDR);
  assign wr_commit    = hdr_wnr && ((data_done && !prot_r)
                        || (chk_done && prot_r && (word_in == ~data_r)));
  assign prot_err_set = hdr_wnr && chk_done && prot_r && (word_in != ~data_r);
  assign wr_cfg       = wr_commit && hit_cfg;
  assign wr_sts       = wr_commit && hit_sts;
  assign cps_legal    = (wr_word_cps >= scr_pkg::CPS_MIN) && (wr_word_cps <= scr_pkg::CPS_MAX);

  assign wr_word     = prot_r ? data_r : word_in;
  assign wr_word_cps = wr_word[scr_pkg::CFG_CPS_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////////
  // configuration register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_r    <= 1'b0;
      fcsve_r   <= 1'b0;
      csalign_r <= 1'b0;
      zalign_r  <= 1'b0;
      thr_r     <= scr_pkg::THR_RST;
      tx_cut_through_en_r   <= 1'b0;
      rx_cut_through_en_r   <= 1'b0;
      prot_r    <= 1'b0;
      cps_r     <= scr_pkg::CPS_RST;
    end else if (wr_cfg) begin
      sync_r    <= sync_r | wr_word[scr_pkg::CFG_SYNC_BIT];
      fcsve_r   <= wr_word[scr_pkg::CFG_FCSVE_BIT];
      csalign_r <= wr_word[scr_pkg::CFG_CSALIGN_BIT];
      zalign_r  <= wr_word[scr_pkg::CFG_ZALIGN_BIT];
      thr_r     <= wr_word[scr_pkg::CFG_THR_LSB +: 2];
      tx_cut_through_en_r   <= wr_word[scr_pkg::CFG_TX_CUT_THROUGH_EN_BIT];
      rx_cut_through_en_r   <= wr_word[scr_pkg::CFG_RX_CUT_THROUGH_EN_BIT];
      prot_r    <= wr_word[scr_pkg::CFG_PROT_BIT];
      if (cps_legal) begin
        cps_r   <= wr_word_cps;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status register: sticky flags, set wins over write-one-to-clear
  logic control_protection_error_nxt;
  logic tx_host_check_seq_error_nxt;

  assign control_protection_error_nxt   = prot_err_set
                      || (control_protection_error_r && !(wr_sts && wr_word[scr_pkg::STS_CONTROL_PROTECTION_ERROR_BIT]));
  assign tx_host_check_seq_error_nxt = tx_host_fcs_bad_i
                      || (tx_host_check_seq_error_r && !(wr_sts && wr_word[scr_pkg::STS_FCSE_BIT]));

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      control_protection_error_r   <= 1'b0;
      tx_host_check_seq_error_r <= 1'b0;
    end else begin
      control_protection_error_r   <= control_protection_error_nxt;
      tx_host_check_seq_error_r <= tx_host_check_seq_error_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data shift out, data changes on falling clock edge
  logic [31:0] rd_hold_r;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_sh_r <= 32'h0000_0000;
    end else if (hdr_done) begin
      out_sh_r <= word_in[scr_pkg::HDR_WNR_BIT] ? 32'h0000_0000 : rd_word;
    end else if (data_done) begin
      out_sh_r <= (!hdr_wnr && prot_r) ? ~rd_hold_r : 32'h0000_0000;
    end else if (sclk_fall) begin
      out_sh_r <= {out_sh_r[30:0], 1'b0};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_hold_r <= 32'h0000_0000;
    end else if (hdr_done) begin
      rd_hold_r <= rd_word;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= !cs_n_s;
      if (sclk_fall) begin
        spi_miso_o  <= out_sh_r[31];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit credit threshold and interrupt line
  logic       starved_r;
  logic       credit_pend_r;
  logic       credit_ok;
  logic       starved_nxt;
  logic       credit_pend_nxt;

  assign credit_ok       = tx_credits_available_i >= scr_pkg::thr_credits(thr_r);
  assign starved_nxt     = (tx_credits_available_i == 8'h00) || (starved_r && !credit_ok);
  assign credit_pend_nxt = (starved_r && credit_ok) || (credit_pend_r && !cs_start);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      starved_r         <= 1'b0;
      credit_pend_r     <= 1'b0;
      interrupt_out_n_o <= 1'b1;
    end else begin
      starved_r         <= starved_nxt;
      credit_pend_r     <= credit_pend_nxt;
      interrupt_out_n_o <= !(credit_pend_nxt || control_protection_error_nxt || tx_host_check_seq_error_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration outputs to the data path
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frames_accept_o            <= 1'b0;
      tx_check_seq_validate_en_o <= 1'b0;
      chip_select_rx_align_en_o  <= 1'b0;
      zero_offset_rx_align_en_o  <= 1'b0;
      tx_cut_through_en_o        <= 1'b0;
      rx_cut_through_en_o        <= 1'b0;
      control_protection_en_o    <= 1'b0;
      chunk_payload_size_o       <= scr_pkg::CPS_RST;
    end else begin
      frames_accept_o            <= sync_r;
      tx_check_seq_validate_en_o <= fcsve_r;
      chip_select_rx_align_en_o  <= csalign_r;
      zero_offset_rx_align_en_o  <= zalign_r;
      tx_cut_through_en_o        <= tx_cut_through_en_r;
      rx_cut_through_en_o        <= rx_cut_through_en_r;
      control_protection_en_o    <= prot_r;
      chunk_payload_size_o       <= cps_r;
    end
  end

  scr_chunk_check u_chunk (
    .mclk_i               (mclk_i),
    .rst_b_i              (rst_b_i),
    .hdr_valid_i          (tx_hdr_valid_i),
    .start_valid_i        (tx_start_valid_i),
    .end_valid_i          (tx_end_valid_i),
    .start_word_offset_i  (tx_start_word_offset_i),
    .end_byte_offset_i    (tx_end_byte_offset_i),
    .chunk_payload_size_i (cps_r),
    .proto_err_o          (tx_protocol_error_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_SYNC_STICKY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    sync_r |=> sync_r)
    else $error("sync bit cleared without reset");

  AST_FRAMES_GATED: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !sync_r |=> !frames_accept_o)
    else $error("frames accepted before sync");

  AST_CPS_RANGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (cps_r >= scr_pkg::CPS_MIN) && (cps_r <= scr_pkg::CPS_MAX))
    else $error("payload size code out of range");

  AST_CFG_RO_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (cfg_rd[31:16] == 16'h0000) && (cfg_rd[7:6] == 2'h0))
    else $error("read-only config bits not zero");

  AST_STS_RO_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    sts_rd[10:9] == 2'h0)
    else $error("timestamp capture bits not zero");

  AST_CONTROL_PROTECTION_ERROR_SET: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    prot_err_set |=> control_protection_error_r ##1 (control_protection_error_r || $past(wr_sts)))
    else $error("protection error not latched");

  AST_FCSE_SET: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    tx_host_fcs_bad_i |=> tx_host_check_seq_error_r && !interrupt_out_n_o)
    else $error("host fcs error not flagged");

  AST_W1C_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    tx_host_check_seq_error_r && !(wr_sts && wr_word[scr_pkg::STS_FCSE_BIT]) |=> tx_host_check_seq_error_r)
    else $error("fcs flag lost without write one");

  AST_CREDIT_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    starved_r && !credit_ok && !credit_pend_r && !control_protection_error_nxt && !tx_host_check_seq_error_nxt |=> interrupt_out_n_o)
    else $error("credit interrupt below threshold");

endmodule : scr_regs

// >>> bench/scr_host_model.sv
// host spi master model issuing mode 0 control transactions
module scr_host_model (
  input  wire logic mclk_i,
  input  wire logic miso_i,
  output logic      chip_select_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    chip_select_n_o = 1'b1;
    sclk_o          = 1'b0;
    mosi_o          = 1'b0;
  end

  // half sclk period of 80 ns, every change lands on a falling mclk
  task automatic half;
    repeat (10) @(negedge mclk_i);
  endtask : half

  // shifts n bits of tx msb first and gathers miso left aligned into rx
  task automatic xfer(input logic [95:0] tx, input int n, output logic [95:0] rx);
    rx = 96'h0;
    chip_select_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_o = tx[95-i];
      half();
      sclk_o = 1'b1;
      rx[95-i] = miso_i;
      half();
      sclk_o = 1'b0;
    end
    half();
    chip_select_n_o = 1'b1;
    // released line shows the inverse so stale data is never mistaken
    mosi_o = ~mosi_o;
    half();
  endtask : xfer
endmodule : scr_host_model

// >>> bench/tb.sv
// self-checking bench for the spi protocol configuration and status registers
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] CA = scr_pkg::CFG_ADDR;
  localparam logic [15:0] SA = scr_pkg::STS_ADDR;

  logic        mclk;
  logic        rst_b;
  logic        cs_n;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        miso_w;
  logic        fcs_bad;
  logic [7:0]  credits;
  logic        hdr_v;
  logic        sv;
  logic        ev;
  logic [3:0]  start_word_offset;
  logic [5:0]  end_byte_offset;
  logic        accept;
  logic [5:0]  ens;
  logic [2:0]  chunk_payload_size;
  logic        perr;
  logic        irq_n;
  logic [95:0] rx;
  logic [31:0] rd_v;
  logic        p;
  int          nb;
  int          miscompares;
  int          cmp_count;
  logic [7:0]  thr [4] = '{8'h01, 8'h04, 8'h08, 8'h10};

  always #4 mclk = ~mclk;

  // undriven miso shows the inverse of the output register
  assign miso_w = miso_oe ? miso : ~miso;

  scr_host_model u_host (
    .mclk_i          (mclk),
    .miso_i          (miso_w),
    .chip_select_n_o (cs_n),
    .sclk_o          (sclk),
    .mosi_o          (mosi)
  );

  scr_regs u_dut (
    .mclk_i                     (mclk),
    .rst_b_i                    (rst_b),
    .chip_select_n_i            (cs_n),
    .spi_sclk_i                 (sclk),
    .spi_mosi_i                 (mosi),
    .spi_miso_o                 (miso),
    .spi_miso_oe_o              (miso_oe),
    .tx_host_fcs_bad_i          (fcs_bad),
    .tx_credits_available_i     (credits),
    .tx_hdr_valid_i             (hdr_v),
    .tx_start_valid_i           (sv),
    .tx_end_valid_i             (ev),
    .tx_start_word_offset_i     (start_word_offset),
    .tx_end_byte_offset_i       (end_byte_offset),
    .frames_accept_o            (accept),
    .tx_check_seq_validate_en_o (ens[5]),
    .chip_select_rx_align_en_o  (ens[4]),
    .zero_offset_rx_align_en_o  (ens[3]),
    .tx_cut_through_en_o        (ens[2]),
    .rx_cut_through_en_o        (ens[1]),
    .control_protection_en_o    (ens[0]),
    .chunk_payload_size_o       (chunk_payload_size),
    .tx_protocol_error_o        (perr),
    .interrupt_out_n_o          (irq_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one control transaction: header, data word, third word when n is 96
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input int n,
                     input logic [31:0] third);
    u_host.xfer({w, 15'h0, a, d, third}, n, rx);
    rd_v = rx[63:32];
  endtask : acc

  // one chunk header, error pulse caught in either of the next two cycles
  task automatic hdr(input logic s, input logic e, input logic [3:0] w, input logic [5:0] b);
    @(negedge mclk);
    sv = s;
    ev = e;
    start_word_offset = w;
    end_byte_offset = b;
    hdr_v = 1'b1;
    @(negedge mclk);
    hdr_v = 1'b0;
    p = perr;
    @(negedge mclk);
    p = p | perr;
  endtask : hdr

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    close_out();
  end

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    fcs_bad = 1'b0;
    credits = 8'h3C;
    hdr_v = 1'b0;
    sv = 1'b0;
    ev = 1'b0;
    start_word_offset = 4'h0;
    end_byte_offset = 6'h00;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    chk("accept", accept, 32'h0);
    chk("cps_out", chunk_payload_size, 32'h6);
    acc(1'b0, CA, 32'h0, 64, 32'h0);
    chk("cfg_reset", rd_v, 32'h0000_0006);
    acc(1'b0, SA, 32'h0, 64, 32'h0);
    chk("sts_reset", rd_v, 32'h0);
    acc(1'b0, 16'h0010, 32'h0, 64, 32'h0);
    chk("unmapped", rd_v, 32'h0);
    // mac append is taken as already cleared by the host
    acc(1'b1, CA, 32'hFFFF_7FDB, 64, 32'h0);
    acc(1'b0, CA, 32'h0, 64, 32'h0);
    chk("cfg_rw", rd_v, 32'h0000_7F03);
    chk("enables", ens, 32'h3E);
    chk("cps_out", chunk_payload_size, 32'h3);
    chk("accept", accept, 32'h0);
    acc(1'b1, CA, 32'h0000_0007, 64, 32'h0);
    acc(1'b0, CA, 32'h0, 64, 32'h0);
    chk("cps_illegal", rd_v, 32'h0000_0003);
    chk("enables_off", ens, 32'h0);
    // credits stay nonzero while chunk headers are offered
    for (int c = 3; c <= 6; c++) begin
      acc(1'b1, CA, 32'(c), 64, 32'h0);
      chk("cps_sel", chunk_payload_size, 32'(c));
      nb = 8 << (c - 3);
      hdr(1'b1, 1'b0, 4'(nb / 4 - 1), 6'h00);
      chk("swo_ok", p, 32'h0);
      hdr(1'b0, 1'b1, 4'h0, 6'(nb - 1));
      chk("ebo_ok", p, 32'h0);
      hdr(1'b0, 1'b0, 4'hF, 6'h3F);
      chk("unqualified", p, 32'h0);
      if (c < 6) begin
        hdr(1'b1, 1'b0, 4'(nb / 4), 6'h00);
        chk("swo_bad", p, 32'h1);
        hdr(1'b0, 1'b1, 4'h0, 6'(nb));
        chk("ebo_bad", p, 32'h1);
      end
    end
    acc(1'b1, CA, 32'h0000_8006, 64, 32'h0);
    chk("accept_on", accept, 32'h1);
    acc(1'b1, CA, 32'h0000_0006, 64, 32'h0);
    acc(1'b0, CA, 32'h0, 64, 32'h0);
    chk("sync_sticky", rd_v, 32'h0000_8006);
    chk("accept_kept", accept, 32'h1);
    rst_b = 1'b0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    chk("accept_rst", accept, 32'h0);
    acc(1'b0, CA, 32'h0, 64, 32'h0);
    chk("cfg_rst2", rd_v, 32'h0000_0006);
    fcs_bad = 1'b1;
    @(negedge mclk);
    fcs_bad = 1'b0;
    repeat (3) @(negedge mclk);
    chk("irq_fcs", irq_n, 32'h0);
    acc(1'b0, SA, 32'h0, 64, 32'h0);
    chk("fcs_set", rd_v, 32'h0000_0800);
    acc(1'b1, SA, 32'h0, 64, 32'h0);
    acc(1'b0, SA, 32'h0, 64, 32'h0);
    chk("fcs_w0", rd_v, 32'h0000_0800);
    acc(1'b1, SA, 32'h0000_0800, 64, 32'h0);
    acc(1'b0, SA, 32'h0, 64, 32'h0);
    chk("fcs_clr", rd_v, 32'h0);
    chk("irq_clr", irq_n, 32'h1);
    acc(1'b1, CA, 32'h0000_0026, 64, 32'h0);
    chk("prot_on", ens, 32'h01);
    acc(1'b1, CA, 32'h0000_0106, 96, 32'h0);
    acc(1'b0, CA, 32'h0, 96, 32'h0);
    chk("bad_wr_drop", rd_v, 32'h0000_0026);
    chk("rd_compl", rx[31:0], 32'hFFFF_FFD9);
    acc(1'b0, SA, 32'h0, 96, 32'h0);
    chk("perr_set", rd_v, 32'h0000_1000);
    chk("irq_perr", irq_n, 32'h0);
    acc(1'b1, SA, 32'h0000_1000, 96, 32'hFFFF_EFFF);
    acc(1'b0, SA, 32'h0, 96, 32'h0);
    chk("perr_clr", rd_v, 32'h0);
    acc(1'b1, CA, 32'h0000_0006, 96, 32'hFFFF_FFF9);
    chk("prot_off", ens, 32'h0);
    for (int t = 0; t < 4; t++) begin
      acc(1'b1, CA, {20'h0, 2'(t), 10'h006}, 64, 32'h0);
      credits = 8'h00;
      repeat (3) @(negedge mclk);
      credits = thr[t] - 8'h01;
      repeat (3) @(negedge mclk);
      chk("irq_below", irq_n, 32'h1);
      credits = thr[t];
      repeat (3) @(negedge mclk);
      chk("irq_at", irq_n, 32'h0);
    end
    acc(1'b0, CA, 32'h0, 64, 32'h0);
    chk("irq_ack", irq_n, 32'h1);
    close_out();
  end
endmodule : tb
